//--- core/stm_pkg.sv
// Constants and carrier types for the torque shut-off monitor
// Summary of operation
// (R1) First safety input open means channel A demands shut-off; closed releases it.
// (R2) Second safety input open means channel B demands shut-off; closed releases it.
// (R3) Power stage drive is cut while either input is open; both closed permit drive.
// (R4) Channel A monitor closes while channel A is shut off, opens when released.
// (R5) Channel B monitor closes while channel B is shut off, opens when released.
// (R6) Path between both monitors closes only when both inputs are open.
// (R7) External test pulses on the safety inputs stay off for at most 1 ms.
// (R8) Torque removal while the motor moves brakes dynamically and raises timing alarm.
// (R9) Controller opens both inputs only after the motor stopped by servo-off or forced stop; the bench opens both with motor_moving high.
// (R10) Controller opens both safety inputs together, never one channel alone; the bench controller model also opens channel A or B alone.
// (R11) Open periods no longer than the test pulse limit leave channel state unchanged.
`default_nettype none
package stm_pkg;
    // Clock and test pulse timing
    localparam int unsigned CLK_FREQ_KHZ = 125000;
    localparam int unsigned TEST_PULSE_MAX_US = 1000;
    localparam int unsigned TEST_PULSE_MAX_CYC = (TEST_PULSE_MAX_US * CLK_FREQ_KHZ) / 1000;
    // Width of the open-period counter, enough for the full limit
    localparam int unsigned FILTER_W = 17;

    // Per-channel filter states
    typedef enum logic [2:0] {
        FLT_SHUTOFF  = 3'b001,
        FLT_RELEASED = 3'b010,
        FLT_GLITCH   = 3'b100
    } stm_filter_state_type;

    // Drive states of the power stage
    typedef enum logic [2:0] {
        DRV_SHUTOFF = 3'b001,
        DRV_ON      = 3'b010,
        DRV_ALARM   = 3'b100
    } stm_drive_state_type;

    // Monitor outputs; a 1 means the output transistor is closed
    typedef struct packed {
        logic shutoff_monitor_a;
        logic shutoff_monitor_b;
        logic monitor_pair_closed;
    } stm_monitor_type;

    localparam stm_monitor_type MONITOR_RESET = 3'h7;
endpackage
`default_nettype wire

//--- core/stm_input_filter.sv
// Test pulse filter and shut-off state of one safety channel
`default_nettype none
module stm_input_filter #(
    parameter int unsigned LIMIT = stm_pkg::TEST_PULSE_MAX_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic input_closed,
    output logic channel_shutoff
);
    stm_pkg::stm_filter_state_type state, next_state;
    logic [stm_pkg::FILTER_W-1:0] open_count, next_open_count;
    localparam logic [stm_pkg::FILTER_W-1:0] LAST_COUNT = stm_pkg::FILTER_W'(LIMIT - 1);

    // Release is immediate; an opening must outlast the test pulse limit
    always_comb begin
        next_state = state;
        next_open_count = open_count;
        unique case (state)
            stm_pkg::FLT_SHUTOFF: begin
                if (input_closed) begin
                    next_state = stm_pkg::FLT_RELEASED; // R1 R2
                end
            end
            stm_pkg::FLT_RELEASED: begin
                if (!input_closed) begin
                    next_state = stm_pkg::FLT_GLITCH; // R11
                    next_open_count = '0;
                end
            end
            stm_pkg::FLT_GLITCH: begin
                if (input_closed) begin
                    next_state = stm_pkg::FLT_RELEASED; // R11
                end else if (open_count == LAST_COUNT) begin
                    next_state = stm_pkg::FLT_SHUTOFF; // R1 R2
                end else begin
                    next_open_count = open_count + 1'b1;
                end
            end
            default: begin
                next_state = stm_pkg::FLT_SHUTOFF;
            end
        endcase
    end

    // Shut-off after reset: safe until the input is seen closed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= stm_pkg::FLT_SHUTOFF;
            open_count <= '0;
        end else begin
            state <= next_state;
            open_count <= next_open_count;
        end
    end

    assign channel_shutoff = state[0];

    // Closed input releases the channel on the next edge
    release_closed_a: assert property (@(posedge clk) disable iff (!rst_b) // R1
        input_closed |=> !channel_shutoff)
        else $error("channel not released after input closed");

    // One-cycle opening never shuts the channel off
    short_pulse_a: assert property (@(posedge clk) disable iff (!rst_b) // R11
        (!channel_shutoff && input_closed) ##1 !input_closed ##1 input_closed
        |-> !channel_shutoff)
        else $error("short open period changed channel state");
endmodule
`default_nettype wire

//--- core/stm_monitor.sv
// Safe torque off monitor: input filters, drive permit, monitors, timing alarm
`default_nettype none
module stm_monitor #(
    parameter int unsigned FILTER_CYCLES = stm_pkg::TEST_PULSE_MAX_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic safety_input_a,
    input wire logic safety_input_b,
    input wire logic motor_moving,
    input wire logic alarm_clear,
    output var stm_pkg::stm_monitor_type shutoff_monitor,
    output logic base_drive_enable,
    output logic dynamic_brake,
    output logic torque_off_timing_alarm
);
    logic chan_a_off;
    logic chan_b_off;
    logic removal_in_motion;
    stm_pkg::stm_drive_state_type drive_state, next_drive_state;
    stm_pkg::stm_monitor_type next_monitor;
    logic next_drive_enable;
    logic next_brake;
    logic next_alarm;

    // One filter per channel; safety_input high means closed to the common
    stm_input_filter #(
        .LIMIT(FILTER_CYCLES)
    ) filt_a (
        .clk(clk),
        .rst_b(rst_b),
        .input_closed(safety_input_a),
        .channel_shutoff(chan_a_off)
    );

    stm_input_filter #(
        .LIMIT(FILTER_CYCLES)
    ) filt_b (
        .clk(clk),
        .rst_b(rst_b),
        .input_closed(safety_input_b),
        .channel_shutoff(chan_b_off)
    );

    // Either channel off while driving a moving motor is the alarm cause
    assign removal_in_motion = drive_state[1] && (chan_a_off || chan_b_off) && motor_moving; // R8

    // Drive state sequencing
    always_comb begin
        next_drive_state = drive_state;
        unique case (drive_state)
            stm_pkg::DRV_SHUTOFF: begin
                if (!chan_a_off && !chan_b_off) begin
                    next_drive_state = stm_pkg::DRV_ON; // R3
                end
            end
            stm_pkg::DRV_ON: begin
                if (removal_in_motion) begin
                    next_drive_state = stm_pkg::DRV_ALARM; // R8
                end else if (chan_a_off || chan_b_off) begin
                    next_drive_state = stm_pkg::DRV_SHUTOFF; // R3
                end
            end
            stm_pkg::DRV_ALARM: begin
                // Alarm only leaves on an explicit clear, drive never restarts by itself
                if (alarm_clear) begin
                    next_drive_state = stm_pkg::DRV_SHUTOFF;
                end
            end
            default: begin
                next_drive_state = stm_pkg::DRV_SHUTOFF;
            end
        endcase
    end

    // Registered outputs; drive, brake and alarm decoded from the next drive state, monitors from the current filtered channels
    always_comb begin
        next_monitor.shutoff_monitor_a = chan_a_off; // R4
        next_monitor.shutoff_monitor_b = chan_b_off; // R5
        next_monitor.monitor_pair_closed = chan_a_off && chan_b_off; // R6
        next_drive_enable = next_drive_state == stm_pkg::DRV_ON; // R3
        next_brake = next_drive_state == stm_pkg::DRV_ALARM; // R8
        next_alarm = next_drive_state == stm_pkg::DRV_ALARM; // R8
    end

    // State and output registers; reset leaves power stage cut
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            drive_state <= stm_pkg::DRV_SHUTOFF;
            shutoff_monitor <= stm_pkg::MONITOR_RESET;
            base_drive_enable <= 1'b0;
            dynamic_brake <= 1'b0;
            torque_off_timing_alarm <= 1'b0;
        end else begin
            drive_state <= next_drive_state;
            shutoff_monitor <= next_monitor;
            base_drive_enable <= next_drive_enable;
            dynamic_brake <= next_brake;
            torque_off_timing_alarm <= next_alarm;
        end
    end

    // Checks sample the registered outputs against the filtered channels;
    // inputs are synchronous, so one clock and one reset cover every check.
    // Two edges separate a closing safety input from its monitor: filter, then output register.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence open_while_moving_s;
        base_drive_enable && motor_moving && (chan_a_off || chan_b_off);
    endsequence

    sequence brake_stop_s;
        torque_off_timing_alarm && dynamic_brake && !base_drive_enable;
    endsequence

    // Opening while the motor stands still only cuts drive
    sequence open_at_rest_s;
        base_drive_enable && !motor_moving && (chan_a_off || chan_b_off);
    endsequence

    sequence quiet_cut_s;
        !base_drive_enable && !torque_off_timing_alarm && !dynamic_brake;
    endsequence

    // Alarm acknowledged in a cycle in which it is shown
    sequence cleared_s;
        torque_off_timing_alarm && alarm_clear;
    endsequence

    // Drive permitted only with both channels released the cycle before
    drive_permit_a: assert property ( // R3
        base_drive_enable |-> !$past(chan_a_off) && !$past(chan_b_off))
        else $error("drive enabled with a channel shut off");

    // Any channel shut-off removes drive on the next edge
    drive_cut_a: assert property ( // R3
        (chan_a_off || chan_b_off) |=> !base_drive_enable)
        else $error("drive not cut after channel shut-off");

    // Monitor A tracks channel A one cycle later
    monitor_a_track_a: assert property ( // R4
        ##1 shutoff_monitor.shutoff_monitor_a == $past(chan_a_off))
        else $error("monitor a disagrees with channel a");

    // Monitor B tracks channel B one cycle later
    monitor_b_track_a: assert property ( // R5
        ##1 shutoff_monitor.shutoff_monitor_b == $past(chan_b_off))
        else $error("monitor b disagrees with channel b");

    // Pair path closed exactly when both monitors are closed
    pair_path_a: assert property ( // R6
        shutoff_monitor.monitor_pair_closed ==
        (shutoff_monitor.shutoff_monitor_a && shutoff_monitor.shutoff_monitor_b))
        else $error("pair path inconsistent with channel monitors");

    // Removal during motion brakes and alarms on the next edge
    motion_alarm_a: assert property ( // R8
        open_while_moving_s |=> brake_stop_s)
        else $error("no brake stop after removal in motion");

    // Alarm holds until cleared
    alarm_hold_a: assert property ( // R8
        (torque_off_timing_alarm && !alarm_clear) |=> torque_off_timing_alarm)
        else $error("timing alarm dropped without clear");

    // Drive only runs with both monitors open
    monitor_drive_a: assert property ( // R3
        base_drive_enable |->
        (!shutoff_monitor.shutoff_monitor_a && !shutoff_monitor.shutoff_monitor_b))
        else $error("drive enabled while a monitor reports shut-off");

    // Closed pair path means the power stage is cut
    pair_cut_a: assert property ( // R6
        shutoff_monitor.monitor_pair_closed |-> !base_drive_enable)
        else $error("drive enabled while pair path closed");

    // Both channels released with no alarm standing starts the drive
    drive_release_a: assert property ( // R3
        (!chan_a_off && !chan_b_off && !torque_off_timing_alarm) |=> base_drive_enable)
        else $error("drive not permitted with both channels released");

    // Closed input opens monitor A two edges later
    monitor_a_open_a: assert property ( // R4
        safety_input_a |-> ##2 !shutoff_monitor.shutoff_monitor_a)
        else $error("monitor a still closed after input a closed");

    // Closed input opens monitor B two edges later
    monitor_b_open_a: assert property ( // R5
        safety_input_b |-> ##2 !shutoff_monitor.shutoff_monitor_b)
        else $error("monitor b still closed after input b closed");

    // Either input closed keeps the pair path open
    pair_open_a: assert property ( // R6
        (safety_input_a || safety_input_b) |-> ##2 !shutoff_monitor.monitor_pair_closed)
        else $error("pair path closed with an input closed");

    // Alarm only rises after drive ran with the motor moving
    alarm_cause_a: assert property ( // R8
        $rose(torque_off_timing_alarm) |-> $past(base_drive_enable) && $past(motor_moving))
        else $error("timing alarm without removal in motion");

    // Removal at rest cuts drive without alarm or brake
    rest_stop_a: assert property ( // R8
        open_at_rest_s |=> quiet_cut_s)
        else $error("removal at rest raised alarm or kept drive");

    // Clear drops alarm and brake on the next edge
    alarm_clear_a: assert property ( // R8
        cleared_s |=> !torque_off_timing_alarm && !dynamic_brake)
        else $error("timing alarm not cleared");

    // Alarm only falls after a clear
    alarm_fall_a: assert property ( // R8
        $fell(torque_off_timing_alarm) |-> $past(alarm_clear))
        else $error("timing alarm fell without clear");

    // After a clear drive waits one cycle, then restarts only with both channels released
    restart_gate_a: assert property ( // R3
        cleared_s |=> !base_drive_enable ##1
        (base_drive_enable == (!$past(chan_a_off) && !$past(chan_b_off))))
        else $error("drive restart after clear ignored channel state");
endmodule
`default_nettype wire

//--- tb/stm_safety_ctrl.sv
// Behavioural model of the external safety controller driving both safety inputs
`default_nettype none
module stm_safety_ctrl #(
    parameter int unsigned PULSE_MAX = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic want_a,
    input wire logic want_b,
    input wire logic pulse_go,
    input wire logic [7:0] pulse_len,
    output logic safety_input_a,
    output logic safety_input_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;

    // Test pulse opens both contacts together; length clamped to the allowed off time
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 8'h00;
            safety_input_a <= 1'b0;
            safety_input_b <= 1'b0;
        end else begin
            if (pulse_go && cnt == 8'h00) begin
                cnt <= (pulse_len > PULSE_MAX) ? 8'(PULSE_MAX) : pulse_len;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
            // Contacts only follow the commands, never open on their own
            safety_input_a <= want_a && (cnt == 8'h00);
            safety_input_b <= want_b && (cnt == 8'h00);
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_stm_monitor.sv
// Self-checking bench for the torque shut-off monitor
`default_nettype none
module tb_stm_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned FILT = 8;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic want_a = 1'b0;
    logic want_b = 1'b0;
    logic pulse_go = 1'b0;
    logic [7:0] pulse_len = 8'h01;
    logic motor_moving = 1'b0;
    logic alarm_clear = 1'b0;
    logic safety_input_a;
    logic safety_input_b;
    stm_pkg::stm_monitor_type shutoff_monitor;
    logic base_drive_enable;
    logic dynamic_brake;
    logic torque_off_timing_alarm;
    logic [5:0] exp_q[$];
    logic [5:0] got;
    logic [5:0] e;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [1:0] combo[4] = '{2'b01, 2'b10, 2'b00, 2'b11};

    always #4 clk = ~clk;

    stm_safety_ctrl #(.PULSE_MAX(FILT)) u_ctrl (.clk(clk), .rst_b(rst_b), .want_a(want_a),
        .want_b(want_b), .pulse_go(pulse_go), .pulse_len(pulse_len),
        .safety_input_a(safety_input_a), .safety_input_b(safety_input_b));

    stm_monitor #(.FILTER_CYCLES(FILT)) u_dut (.clk(clk), .rst_b(rst_b),
        .safety_input_a(safety_input_a), .safety_input_b(safety_input_b),
        .motor_moving(motor_moving), .alarm_clear(alarm_clear),
        .shutoff_monitor(shutoff_monitor), .base_drive_enable(base_drive_enable),
        .dynamic_brake(dynamic_brake), .torque_off_timing_alarm(torque_off_timing_alarm));

    // Outputs are settled by the falling edge; oldest note is compared then
    always @(negedge clk) begin
        got = {shutoff_monitor, base_drive_enable, dynamic_brake, torque_off_timing_alarm};
        if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            n_tests++;
            if (got !== e) begin
                n_mismatch++;
                $display("Error at %0t: outputs %b, expected %b", $time, got, e);
            end
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One note per cycle so the watcher never falls behind
    task automatic chk(input logic [5:0] v);
        exp_q.push_back(v);
        @(posedge clk);
    endtask

    task automatic close_out();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog against a hung sequence
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        close_out();
    end

    initial begin
        void'($urandom(32'h9c0929db));
        step(3);
        rst_b <= 1'b1;
        chk(6'b111_000);
        want_a <= 1'b1;
        want_b <= 1'b1;
        step(4);
        chk(6'b000_100);
        // Test pulses up to the limit, the first exactly at it
        for (int i = 0; i < 4; i++) begin
            pulse_len <= (i == 0) ? 8'(FILT) : 8'(1 + $urandom % FILT);
            pulse_go <= 1'b1;
            @(posedge clk);
            pulse_go <= 1'b0;
            repeat (FILT + 4) chk(6'b000_100);
        end
        // Every input combination with the motor at rest
        foreach (combo[i]) begin
            want_a <= combo[i][1];
            want_b <= combo[i][0];
            step(FILT + 5);
            chk({~combo[i][1], ~combo[i][0], ~|combo[i], &combo[i], 2'b00});
        end
        // Removal during motion trips the timing alarm
        motor_moving <= 1'b1;
        want_a <= 1'b0;
        want_b <= 1'b0;
        step(FILT + 5);
        chk(6'b111_011);
        motor_moving <= 1'b0;
        want_a <= 1'b1;
        want_b <= 1'b1;
        step(5);
        chk(6'b000_011);
        alarm_clear <= 1'b1;
        @(posedge clk);
        alarm_clear <= 1'b0;
        step(3);
        chk(6'b000_100);
        step(2);
        close_out();
    end
endmodule
`default_nettype wire
